//--- core/isc_engine.sv
/*
  Two-wire master/slave engine reporting one status code per bus event.
  Assumes an AHB-Lite master on CLK and open-drain pads outside that resolve
  SCL and SDA from the output enables.
*/
`timescale 1ns/1ns
module isc_engine
  import isc_pkg::*;
#(
  parameter int HALF_CYC = SCL_HALF_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        SCL_I,
  output logic             SCL_O,
  output logic             SCL_OE,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE
);

  localparam logic [15:0] HALF_M1 = 16'(HALF_CYC - 1);

  isc_ctl_t   ctl;
  isc_ctl_t   next_ctl;
  isc_state_t st;
  logic [7:0]  adr;
  logic [7:0]  sh;
  logic [7:0]  stat;
  logic [7:0]  ph_addr;
  logic [7:0]  setm;
  logic [7:0]  clrm;
  logic [15:0] cnt;
  logic [3:0]  bitn;
  logic        ph_wr;
  logic        scl_m;
  logic        scl_s;
  logic        scl_p;
  logic        sda_m;
  logic        sda_s;
  logic        sda_p;
  logic        ack_n;
  logic        addr_ph;
  logic        mdir;
  logic        rpt;
  logic        lost;
  logic        saddr;
  logic        sgc;
  logic        stx;
  logic        busy;
  logic        si_q;
  logic        ev_si;
  logic        ev_start_clr;
  logic        ev_stop_clr;
  logic        scl_oe;
  logic        sda_oe;

  function automatic logic [7:0] ctl_byte(input isc_ctl_t c);
    logic [7:0] b;
    b = 8'h00;
    b[B_EN] = c.en;
    b[B_START] = c.start;
    b[B_STOP] = c.stop;
    b[B_SI] = c.si;
    b[B_ACK] = c.ack;
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY

  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ph_wr <= 1'b0;
      ph_addr <= 8'h00;
    end else begin
      ph_wr <= HSEL && HTRANS[1] && HWRITE && HREADY;
      ph_addr <= HADDR[7:0];
    end
  end

  // read data is sampled at the address phase, so it stands in the data phase
  always_ff @(posedge CLK) begin
    if (RESET) begin
      HRDATA <= 32'h0000_0000;
    end else if (HSEL && HTRANS[1] && !HWRITE && HREADY) begin
      case (HADDR[7:0])
        A_CTL_SET: HRDATA <= {24'h00_0000, ctl_byte(ctl)};
        A_STAT:    HRDATA <= {24'h00_0000, stat};
        A_DATA:    HRDATA <= {24'h00_0000, sh};
        A_ADR:     HRDATA <= {24'h00_0000, adr};
        default:   HRDATA <= 32'h0000_0000;
      endcase
    end
  end

  assign setm = (ph_wr && ph_addr == A_CTL_SET) ? HWDATA[7:0] : 8'h00;
  assign clrm = (ph_wr && ph_addr == A_CTL_CLR) ? HWDATA[7:0] : 8'h00;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      adr <= RST_ADR;
    end else if (ph_wr && ph_addr == A_ADR) begin
      adr <= HWDATA[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control bits; hardware set of the flag wins over a software clear

  always_comb begin
    next_ctl = ctl;
    next_ctl.en = (ctl.en | setm[B_EN]) & ~clrm[B_EN]; // see R1
    next_ctl.ack = (ctl.ack | setm[B_ACK]) & ~clrm[B_ACK]; // see R5
    next_ctl.start = (ctl.start & ~clrm[B_START] & ~ev_start_clr) | setm[B_START]; // see R2
    next_ctl.stop = (ctl.stop & ~ev_stop_clr) | setm[B_STOP]; // see R3
    next_ctl.si = (ctl.si & ~clrm[B_SI]) | ev_si; // see R4
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctl <= '0;
      si_q <= 1'b0;
    end else begin
      ctl <= next_ctl;
      si_q <= ctl.si;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the link clock is just another sampled input

  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SCL_OE = scl_oe;
  assign SDA_OE = sda_oe;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      {scl_m, scl_s, scl_p} <= 3'h7;
      {sda_m, sda_s, sda_p} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_p} <= {SCL_I, scl_m, scl_s};
      {sda_m, sda_s, sda_p} <= {SDA_I, sda_m, sda_s};
    end
  end

  wire scl_rise = scl_s && !scl_p;
  wire scl_fall = !scl_s && scl_p;
  wire start_det = scl_s && scl_p && sda_p && !sda_s;
  wire stop_det = scl_s && scl_p && !sda_p && sda_s;
  wire tx_byte = addr_ph || !mdir;
  wire own_m = sh[7:1] == adr[7:1];
  wire gen_m = sh[7:1] == 7'h00 && adr[0] && !sh[0];

  ////////////////////////////////////////////////////////////////////////////
  // shift register: every bit on the wire is sampled, own bits included,
  // which lets a master that lost the address continue as a slave

  always_ff @(posedge CLK) begin
    if (RESET) begin
      sh <= 8'h00;
      ack_n <= 1'b1;
    end else if (scl_rise && (st == M_HIGH || st == S_BIT)) begin
      if (bitn[3]) begin
        ack_n <= sda_s;
      end else begin
        sh <= {sh[6:0], sda_s};
      end
    end else if (ph_wr && ph_addr == A_DATA) begin
      sh <= HWDATA[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus engine

  always_ff @(posedge CLK) begin
    if (RESET) begin
      st <= S_IDLE;
      cnt <= 16'h0000;
      bitn <= 4'h0;
      addr_ph <= 1'b0;
      mdir <= 1'b0;
      rpt <= 1'b0;
      lost <= 1'b0;
      saddr <= 1'b0;
      sgc <= 1'b0;
      stx <= 1'b0;
      busy <= 1'b0;
      stat <= ST_IDLE;
      ev_si <= 1'b0;
      ev_start_clr <= 1'b0;
      ev_stop_clr <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      ev_si <= 1'b0;
      ev_start_clr <= 1'b0;
      ev_stop_clr <= 1'b0;
      cnt <= cnt + 16'h0001;
      if (start_det) begin
        busy <= 1'b1;
      end else if (stop_det) begin
        busy <= 1'b0;
      end
      if (si_q && !ctl.si) begin
        stat <= ST_IDLE; // see R23
      end
      case (st)
        S_IDLE: begin
          scl_oe <= 1'b0;
          sda_oe <= 1'b0;
          cnt <= 16'h0000;
          saddr <= 1'b0;
          stx <= 1'b0;
          if (ctl.en && ctl.stop && !ctl.si) begin
            // no STOP on the wire: act as if one was seen
            ev_stop_clr <= 1'b1; // see R7
            busy <= 1'b0;
          end else if (ctl.en && start_det) begin
            st <= S_BIT;
            bitn <= 4'h0;
            addr_ph <= 1'b1;
            lost <= 1'b0;
          end else if (ctl.en && ctl.start && !busy && !ctl.si && !ev_si) begin
            st <= M_START; // see R6
            rpt <= 1'b0;
          end
        end
        M_RS: begin
          sda_oe <= 1'b0;
          if (cnt == HALF_M1) begin
            scl_oe <= 1'b0;
            cnt <= 16'h0000;
            st <= M_START;
          end
        end
        M_START: begin
          scl_oe <= 1'b0;
          if (!scl_s || !sda_s) begin
            cnt <= 16'h0000;
          end else if (cnt == HALF_M1) begin
            sda_oe <= 1'b1;
            cnt <= 16'h0000;
            st <= M_HOLD;
          end
        end
        M_HOLD: begin
          if (cnt == HALF_M1) begin
            scl_oe <= 1'b1;
            ev_si <= 1'b1;
            ev_start_clr <= 1'b1;
            stat <= rpt ? ST_RSTART : ST_START; // see R8
            addr_ph <= 1'b1;
            lost <= 1'b0;
            st <= M_WAIT;
          end
        end
        M_WAIT: begin
          scl_oe <= 1'b1; // see R24
          cnt <= 16'h0000;
          if (!ctl.si && !ev_si) begin
            if (ctl.stop) begin
              sda_oe <= 1'b1; // see R3
              st <= M_STOP;
            end else if (ctl.start) begin
              rpt <= 1'b1;
              st <= M_RS;
            end else begin
              bitn <= 4'h0;
              st <= M_LOW;
            end
          end
        end
        M_LOW: begin
          scl_oe <= 1'b1;
          // data changes only once the low level has been seen through the sync
          if (cnt == SETUP_CYC) begin
            sda_oe <= bitn[3] ? (!tx_byte && ctl.ack) : (tx_byte && !sh[7]); // see R14
          end
          if (cnt == HALF_M1) begin
            scl_oe <= 1'b0;
            cnt <= 16'h0000;
            st <= M_HIGH;
          end
        end
        M_HIGH: begin
          if (!scl_s) begin
            cnt <= 16'h0000; // slaves may stretch the clock
          end
          if (start_det || stop_det) begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            st <= S_IDLE;
            // at a byte boundary another master's repeated start: back off quietly
            if (bitn != 4'h0) begin
              stat <= ST_BUSERR; // see R22
              ev_si <= 1'b1;
            end
          end else if (scl_rise && !bitn[3] && tx_byte && sh[7] && !sda_s) begin
            lost <= 1'b1;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            if (addr_ph) begin
              st <= S_BIT;
            end else begin
              stat <= ST_ARB; // see R12
              ev_si <= 1'b1;
              st <= S_IDLE;
            end
          end else if (cnt == HALF_M1 && scl_s) begin
            scl_oe <= 1'b1;
            cnt <= 16'h0000;
            if (!bitn[3]) begin
              bitn <= 4'(bitn + 4'h1);
              st <= M_LOW;
            end else begin
              ev_si <= 1'b1;
              addr_ph <= 1'b0;
              st <= M_WAIT;
              if (addr_ph) begin
                mdir <= sh[0]; // see R9
                if (sh[0]) begin
                  stat <= ack_n ? ST_AR_NAK : ST_AR_ACK; // see R13
                end else begin
                  stat <= ack_n ? ST_AW_NAK : ST_AW_ACK; // see R10
                end
              end else if (mdir) begin
                stat <= ack_n ? ST_RX_NAK : ST_RX_ACK; // see R14
              end else begin
                stat <= ack_n ? ST_TX_NAK : ST_TX_ACK; // see R11
              end
            end
          end
        end
        M_STOP: begin
          if (cnt == HALF_M1) begin
            scl_oe <= 1'b0;
            cnt <= 16'h0000;
            st <= M_STOPH;
          end
        end
        M_STOPH: begin
          if (!scl_s) begin
            cnt <= 16'h0000;
          end else if (cnt == HALF_M1) begin
            sda_oe <= 1'b0;
            ev_stop_clr <= 1'b1;
            st <= S_IDLE;
          end
        end
        S_BIT: begin
          scl_oe <= 1'b0;
          if (start_det || stop_det) begin
            sda_oe <= 1'b0;
            st <= S_IDLE;
            if (saddr) begin
              stat <= (bitn == 4'h0) ? ST_SR_END : ST_BUSERR; // see R18
              ev_si <= 1'b1;
            end else if (start_det) begin
              st <= S_BIT;
              bitn <= 4'h0;
              addr_ph <= 1'b1;
            end
          end else if (scl_fall && bitn == 4'h7) begin
            bitn <= 4'h8;
            if (!addr_ph) begin
              sda_oe <= !stx && ctl.ack; // see R16
            end else if (ctl.ack && (own_m || gen_m)) begin
              sda_oe <= 1'b1;
              saddr <= 1'b1;
              sgc <= gen_m;
              stx <= own_m && sh[0];
            end else begin
              sda_oe <= 1'b0;
              st <= S_IDLE;
              if (lost) begin
                stat <= ST_ARB; // see R12
                ev_si <= 1'b1;
              end
            end
          end else if (scl_fall && bitn[3]) begin
            scl_oe <= 1'b1; // see R24
            sda_oe <= 1'b0;
            ev_si <= 1'b1; // see R21
            addr_ph <= 1'b0;
            lost <= 1'b0;
            st <= S_WAIT;
            if (addr_ph) begin
              if (stx) begin
                stat <= lost ? ST_OWN_RL : ST_OWN_R; // see R19
              end else if (sgc) begin
                stat <= lost ? ST_GEN_WL : ST_GEN_W; // see R15
              end else begin
                stat <= lost ? ST_OWN_WL : ST_OWN_W; // see R15
              end
            end else if (stx) begin
              stat <= ack_n ? ST_ST_NAK : (ctl.ack ? ST_ST_ACK : ST_ST_LAST); // see R20
              saddr <= !ack_n && ctl.ack;
            end else if (sgc) begin
              stat <= ack_n ? ST_GR_NAK : ST_GR_ACK; // see R17
              saddr <= !ack_n;
            end else begin
              stat <= ack_n ? ST_SR_NAK : ST_SR_ACK; // see R16
              saddr <= !ack_n;
            end
          end else if (scl_fall) begin
            bitn <= 4'(bitn + 4'h1);
            sda_oe <= stx && !sh[7]; // see R19
          end
        end
        S_WAIT: begin
          // SDA is set up here while SCL is still held; S_BIT frees SCL next cycle
          if (!ctl.si && !ev_si) begin
            bitn <= 4'h0;
            sda_oe <= saddr && stx && !sh[7];
            st <= saddr ? S_BIT : S_IDLE;
          end
        end
        default: begin
          st <= S_IDLE;
        end
      endcase
      if (!ctl.en) begin
        st <= S_IDLE;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  en_set_a: assert property (setm == 8'h44 && clrm == 8'h00 |=> ctl.en && ctl.ack) // see R1
    else $error("enable write did not set enable and acknowledge");
  start_set_a: assert property (setm[B_START] |=> ctl.start) // see R2
    else $error("start request not set");
  stop_set_a: assert property (setm == 8'h14 && clrm == 8'h00 |=> ctl.stop && ctl.ack) // see R3
    else $error("stop request not set");
  si_clr_a: assert property (clrm == 8'h08 && !ev_si |=> !ctl.si) // see R4
    else $error("flag not cleared");
  nack_clr_a: assert property (clrm == 8'h0C && !ev_si && !setm[B_ACK] |=> !ctl.si && !ctl.ack) // see R5
    else $error("flag and acknowledge not cleared");
  retry_a: assert property (st == S_IDLE && ctl.en && ctl.start && !ctl.stop && !busy && !ctl.si
    && !ev_si && !start_det |=> st == M_START) // see R6
    else $error("pending start not issued on free bus");
  start_code_a: assert property (st == M_HOLD && cnt == HALF_M1 && ctl.en
    |=> (stat == ST_START || stat == ST_RSTART) ##1 ctl.si) // see R8
    else $error("start code missing");
  dir_a: assert property ($changed(stat) && stat == ST_AR_ACK |-> mdir) // see R9
    else $error("read address without receive direction");
  buserr_a: assert property (st == M_HIGH && (start_det || stop_det) && bitn != 4'h0 && ctl.en
    |=> st == S_IDLE && stat == ST_BUSERR && !SCL_OE ##1 ctl.si) // see R22
    else $error("bus error not reported");
  idle_a: assert property (stat == ST_IDLE |-> !ctl.si) // see R23
    else $error("idle code with flag set");
  hold_a: assert property ((st == M_WAIT || st == S_WAIT) && ctl.si |-> SCL_OE) // see R24
    else $error("clock released while flag set");

  cover property (st == M_WAIT && stat == ST_TX_ACK);
  cover property (st == S_WAIT && stat == ST_OWN_W);
  cover property (stat == ST_ARB && ctl.si);
  cover property (stat == ST_BUSERR && ctl.si);

endmodule

//--- core/isc_pkg.sv
/*
  Shared constants, types and register map of the two-wire state code engine.
  Assumes one 25 MHz system clock and an AHB-Lite master reaching the registers.
*/
// How it works
// R1 - set 0x44 enables interface and acknowledge; set 0x40 enables interface only
// R2 - set 0x20 requests a START and a master transfer
// R3 - set 0x14 requests STOP with acknowledge; recovers to idle slave after error
// R4 - clear 0x08 drops the interrupt flag so the bus action proceeds
// R5 - clear 0x0C drops the flag and acknowledge, so next byte gets NOT ACK
// R6 - set 0x24 keeps a start pending until the bus is free
// R7 - after code 0x00 a stop request just releases lines, no STOP sent
// R8 - code 0x08 after START, 0x10 after repeated START; address byte follows
// R9 - direction bit of the sent address picks transmit or receive states
// R10 - write address: 0x18 on ACK, 0x20 on NOT ACK
// R11 - master data sent: 0x28 on ACK, 0x30 on NOT ACK
// R12 - lost arbitration releases bus, reports 0x38; pending start retries later
// R13 - read address: 0x40 on ACK, 0x48 on NOT ACK
// R14 - master data received: 0x50 acknowledged, 0x58 not; follows acknowledge bit
// R15 - addressed for write: 0x60 own, 0x70 general call; 0x68, 0x78 after loss
// R16 - own-address receive: 0x80 on ACK, 0x88 on NOT ACK then idle
// R17 - general call receive: 0x90 on ACK, 0x98 on NOT ACK then idle
// R18 - STOP or repeated START while addressed: 0xA0, back to idle slave
// R19 - own read address 0xA8, 0xB0 after loss; 0xB8 after acknowledged byte
// R20 - slave transmit: 0xC0 on NOT ACK, 0xC8 on last acknowledged byte
// R21 - every interrupt shows one of 26 codes for software to branch on
// R22 - misplaced START or STOP: idle slave, release, flag set, code 0x00
// R23 - code 0xF8 means nothing to report and the flag is clear
// R24 - serial clock is held low while the interrupt flag is set, except after codes 0x00, 0x38 and 0xA0, which release it
package isc_pkg;

  localparam logic [7:0] A_CTL_SET = 8'h00;
  localparam logic [7:0] A_STAT    = 8'h04;
  localparam logic [7:0] A_DATA    = 8'h08;
  localparam logic [7:0] A_ADR     = 8'h0C;
  localparam logic [7:0] A_CTL_CLR = 8'h18;

  localparam int B_EN    = 6;
  localparam int B_START = 5;
  localparam int B_STOP  = 4;
  localparam int B_SI    = 3;
  localparam int B_ACK   = 2;

  localparam logic [7:0] ST_BUSERR  = 8'h00;
  localparam logic [7:0] ST_START   = 8'h08;
  localparam logic [7:0] ST_RSTART  = 8'h10;
  localparam logic [7:0] ST_AW_ACK  = 8'h18;
  localparam logic [7:0] ST_AW_NAK  = 8'h20;
  localparam logic [7:0] ST_TX_ACK  = 8'h28;
  localparam logic [7:0] ST_TX_NAK  = 8'h30;
  localparam logic [7:0] ST_ARB     = 8'h38;
  localparam logic [7:0] ST_AR_ACK  = 8'h40;
  localparam logic [7:0] ST_AR_NAK  = 8'h48;
  localparam logic [7:0] ST_RX_ACK  = 8'h50;
  localparam logic [7:0] ST_RX_NAK  = 8'h58;
  localparam logic [7:0] ST_OWN_W   = 8'h60;
  localparam logic [7:0] ST_OWN_WL  = 8'h68;
  localparam logic [7:0] ST_GEN_W   = 8'h70;
  localparam logic [7:0] ST_GEN_WL  = 8'h78;
  localparam logic [7:0] ST_SR_ACK  = 8'h80;
  localparam logic [7:0] ST_SR_NAK  = 8'h88;
  localparam logic [7:0] ST_GR_ACK  = 8'h90;
  localparam logic [7:0] ST_GR_NAK  = 8'h98;
  localparam logic [7:0] ST_SR_END  = 8'hA0;
  localparam logic [7:0] ST_OWN_R   = 8'hA8;
  localparam logic [7:0] ST_OWN_RL  = 8'hB0;
  localparam logic [7:0] ST_ST_ACK  = 8'hB8;
  localparam logic [7:0] ST_ST_NAK  = 8'hC0;
  localparam logic [7:0] ST_ST_LAST = 8'hC8;
  localparam logic [7:0] ST_IDLE    = 8'hF8;

  localparam logic [7:0] RST_ADR = 8'h00;

  localparam int CLK_NS       = 40;
  localparam int SCL_HALF_NS  = 5000;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] SETUP_CYC = 16'h0003;

  typedef struct packed {
    logic en;
    logic start;
    logic stop;
    logic si;
    logic ack;
  } isc_ctl_t;

  typedef enum {
    S_IDLE, M_RS, M_START, M_HOLD, M_WAIT, M_LOW, M_HIGH, M_STOP, M_STOPH,
    S_BIT, S_WAIT
  } isc_state_t;

endpackage

//--- test/isc_slave_model.sv
/*
  Bus target on the two-wire link: one 7-bit address, acknowledges written
  bytes, answers reads with a fixed byte until the master returns NOT ACK.
  Assumes an open-drain wire with a pull-up, resolved by the bench.
*/
`timescale 1ns/1ns
module isc_slave_model #(
  parameter logic [6:0] ADDR = 7'h5a,
  parameter logic [7:0] RD   = 8'hc3
) (
  input  wire logic scl,
  input  wire logic sda,
  output logic      sda_oe
);
  logic [7:0] sh;
  logic       first;
  logic       sel;
  logic       tx;
  logic       ack;
  logic       go;
  int         n;

  initial begin
    sda_oe = 1'b0;
    go = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // start or stop restarts framing and frees the data line
  always @(sda) begin
    if (scl === 1'b1) begin
      disable xfer;
      sda_oe = 1'b0;
      go = !sda;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always begin : xfer
    wait (go === 1'b1);
    go = 1'b0;
    first = 1'b1;
    sel = 1'b0;
    tx = 1'b0;
    forever begin
      for (n = 7; n >= 0; n--) begin
        // msb first, changed only while the clock is low
        if (tx) sda_oe = ~RD[n];
        @(posedge scl) sh[n] = sda;
        @(negedge scl);
      end
      ack = !tx && (first ? (sh[7:1] == ADDR) : sel);
      if (first) sel = ack;
      sda_oe = ack;
      @(posedge scl) if (tx && sda) begin
        tx = 1'b0;
        sel = 1'b0;
      end
      @(negedge scl);
      sda_oe = 1'b0;
      if (first && sel) tx = sh[0];
      first = 1'b0;
    end
  end
endmodule

//--- test/tb.sv
/*
  Self-checking bench of the state code engine: register traffic over
  AHB-Lite, master write and read against the target model.
  Assumes the package map and codes; the open-drain wire is resolved here.
*/
`timescale 1ns/1ns
module tb;
  import isc_pkg::*;
  localparam logic [6:0] TGT    = 7'h5a;
  localparam logic [7:0] TGT_RD = 8'hc3;

  logic        clk, reset, hsel, hwrite, hreadyout, hresp;
  logic        scl_o, scl_oe, sda_o, sda_oe, sl_oe;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rdata, seed;
  logic [7:0]  q[$];
  logic [7:0]  e_m;
  int          miscompares, n_compared;
  wire logic   scl, sda;
  event        got;

  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (sda_oe ? sda_o : 1'b1) & ~sl_oe;

  isc_engine #(.HALF_CYC(8)) i_dut (
    .CLK(clk), .RESET(reset), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .SCL_I(scl), .SCL_O(scl_o), .SCL_OE(scl_oe),
    .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe)
  );

  isc_slave_model #(.ADDR(TGT), .RD(TGT_RD)) i_tgt (
    .scl(scl), .sda(sda), .sda_oe(sl_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic ahb(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rdata = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    ahb(1'b0, a, 8'h00);
    ->got;
  endtask

  task automatic wait_bit(input int b, input logic v);
    ahb(1'b0, A_CTL_SET, 8'h00);
    while (rdata[b] !== v) ahb(1'b0, A_CTL_SET, 8'h00);
  endtask

  // software answer to one state, then the code of the next one
  task automatic step(input logic [7:0] set, input logic [7:0] clr, input logic [7:0] e);
    ahb(1'b1, A_CTL_SET, set);
    ahb(1'b1, A_CTL_CLR, clr);
    wait_bit(B_SI, 1'b1);
    rd(A_STAT, e);
  endtask

  task automatic stop_bus();
    ahb(1'b1, A_CTL_SET, 8'h14);
    ahb(1'b1, A_CTL_CLR, 8'h08);
    wait_bit(B_STOP, 1'b0);
    rd(A_STAT, ST_IDLE);
  endtask

  task automatic tally_and_finish();
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // read word and response of the transfer that just ended
  task automatic compare_read(input logic [7:0] e);
    n_compared++;
    if (rdata !== {24'h00_0000, e}) begin
      miscompares++;
      $display("CHECK FAILED %0t read %h expected %h", $time, rdata, e);
    end
    if (hresp !== 1'b0) begin
      miscompares++;
      $display("CHECK FAILED %0t error response on read", $time);
    end
  endtask

  always @(got) begin
    e_m = q.pop_front();
    compare_read(e_m);
  end

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // whole run is a few thousand cycles at the short half period
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    reset <= 1'b1;
    hsel <= 1'b0;
    hwrite <= 1'b0;
    htrans <= 2'b00;
    haddr <= '0;
    hwdata <= '0;
    seed = 32'h0000_dc40;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rd(A_STAT, ST_IDLE);
    rd(A_CTL_SET, 8'h00);
    rd(8'h14, 8'h00);
    ahb(1'b1, A_CTL_SET, 8'h40);
    rd(A_CTL_SET, 8'h40);
    ahb(1'b1, A_CTL_CLR, 8'h44);
    ahb(1'b1, A_CTL_SET, 8'h44);
    rd(A_CTL_SET, 8'h44);
    ahb(1'b1, A_ADR, 8'h22);
    step(8'h20, 8'h00, ST_START);
    ahb(1'b1, A_DATA, {7'h11, 1'b0});
    step(8'h00, 8'h08, ST_AW_NAK);
    stop_bus();
    step(8'h20, 8'h00, ST_START);
    ahb(1'b1, A_DATA, {7'h11, 1'b1});
    step(8'h00, 8'h08, ST_AR_NAK);
    stop_bus();
    step(8'h20, 8'h00, ST_START);
    ahb(1'b1, A_DATA, {TGT, 1'b0});
    step(8'h00, 8'h08, ST_AW_ACK);
    repeat (2) begin
      seed = xs(seed);
      ahb(1'b1, A_DATA, seed[7:0]);
      step(8'h00, 8'h08, ST_TX_ACK);
    end
    step(8'h20, 8'h08, ST_RSTART);
    ahb(1'b1, A_DATA, {TGT, 1'b1});
    step(8'h00, 8'h08, ST_AR_ACK);
    step(8'h00, 8'h08, ST_RX_ACK);
    rd(A_DATA, TGT_RD);
    step(8'h00, 8'h0c, ST_RX_NAK);
    rd(A_DATA, TGT_RD);
    stop_bus();
    rd(A_CTL_SET, 8'h44);
    tally_and_finish();
  end
endmodule
